/* File: bench/ssd_builder_asserts.sv */
// Port-level assertions for the sense report builder
`timescale 1ns/1ps
module ssd_builder_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Sense stream
    input wire logic [7:0] sense_data,
    input wire logic       sense_valid,
    input wire logic       sense_last,
    input wire logic       sense_ready
);
    logic [6:0] idx_ff;
    logic       fix_ff;
    logic       vld_ff;
    wire        take = sense_valid && sense_ready;
    wire        fb   = sense_valid && fix_ff;
    // Byte position in the report, rewound after the last byte
    always_ff @(posedge clk) begin
        if (rst || (take && sense_last)) idx_ff <= 7'h00;
        else if (take) idx_ff <= idx_ff + 7'h01;
    end
    // Layout and valid bit seen in byte 0, used by the later byte checks
    always_ff @(posedge clk) begin
        if (rst) begin
            fix_ff <= 1'b0;
            vld_ff <= 1'b0;
        end else if (take && idx_ff == 7'h00) begin
            fix_ff <= sense_data[6:1] == 6'h38;
            vld_ff <= sense_data[7];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_HOLD: assert property (sense_valid && !sense_ready |=> sense_valid && $stable(sense_data)
        && $stable(sense_last)) else $error("sense byte changed before it was taken");
    AST_GAP: assert property (take |=> !sense_valid [*2]) else $error("sense valid back too soon");
    AST_CODE: assert property (sense_valid && idx_ff == 7'h00 |-> sense_data[6:0] inside {[7'h70:7'h73]})
        else $error("bad response code");
    AST_B1: assert property (fb && idx_ff == 7'h01 |-> sense_data == 8'h00) else $error("byte 1 not zero");
    AST_B2: assert property (fb && idx_ff == 7'h02 |-> sense_data[7:6] == 2'b00 && !sense_data[4]
        && sense_data[3:0] != 4'hF) else $error("byte 2 bad");
    AST_MM: assert property (fb && idx_ff == 7'h02 && sense_data[5] |-> vld_ff)
        else $error("mismatch flag without valid");
    AST_INFO0: assert property (fb && !vld_ff && idx_ff inside {[7'h03:7'h06]} |-> sense_data == 8'h00)
        else $error("info bytes not zero");
    AST_B7: assert property (fb && idx_ff == 7'h07 |-> sense_data == 8'h18) else $error("byte 7 bad");
    AST_CSI: assert property (fb && idx_ff inside {[7'h08:7'h0B]} |-> sense_data == 8'h00)
        else $error("bytes 8-11 not zero");
    AST_LEN: assert property (sense_valid && idx_ff != 7'h00 |-> idx_ff < (fix_ff ? 7'd32 : 7'd60))
        else $error("report too long");
endmodule // ssd_builder_asserts
bind ssd_builder ssd_builder_asserts u_chk (.clk(clk), .rst(rst), .sense_data(sense_data),
    .sense_valid(sense_valid), .sense_last(sense_last), .sense_ready(sense_ready));

/* File: bench/ssd_builder_tb_top.sv */
// Self-checking bench for the sense report builder
`timescale 1ns/1ps
module ssd_builder_tb_top;
    import ssd_pkg::*;
    logic        clk, rst, clr, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sv, sl, sr, inh;
    logic [7:0]  awaddr, araddr, sd, opc, asc, ascq, alloc;
    logic [31:0] wdata, rdata, vend, rd;
    logic [1:0]  bresp, rresp;
    logic [7:0]  rx [0:63];
    logic [6:0]  rxn, kbits;
    logic        dsel, defer, reqs, infov, prior, cdb, ksv, mm;
    logic [3:0]  key;
    logic [15:0] s16;
    logic [63:0] info;
    logic [3:0]  keys [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
    int          num_errors = 0;
    int          checks_done = 0;

    ssd_builder dut (.clk(clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense_data(sd),
        .sense_valid(sv), .sense_last(sl), .sense_ready(sr), .medium_inhibit(inh));
    ssd_initiator_model ini (.clk(clk), .rst(rst), .clr(clr), .sense_data(sd), .sense_valid(sv),
        .sense_ready(sr), .rx_mem(rx), .rx_cnt(rxn));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Expected transfer length; a reserved key sends nothing
    function automatic logic [6:0] exp_len();
        logic [6:0] l;
        l = dsel ? SSD_LEN_DESC : SSD_LEN_FIXED;
        if (key == SSD_KEY_RSVD) return 7'h00;
        if (reqs && alloc < {1'b0, l}) return alloc[6:0];
        return l;
    endfunction

    // Expected fixed layout byte, multi-byte fields most significant first
    function automatic logic [7:0] exp_byte(input int i);
        logic       mme, vld;
        logic [7:0] b [0:31];
        mme = mm && (opc == SSD_OPC_RD_LONG || opc == SSD_OPC_WR_LONG);
        // Residues are signed, so only an address faces the ceiling
        vld = (infov || mme) && (mme || info <= SSD_INFO_MAX);
        b = '{default: 8'h00};
        b[0] = {vld, (defer && prior) ? SSD_RC_FIX_DEF : SSD_RC_FIX_CUR};
        b[2] = {2'b00, mme, 1'b0, key};
        if (vld) {b[3], b[4], b[5], b[6]} = info[31:0];
        b[7] = SSD_ADDL_FIXED;
        b[12] = asc;
        b[13] = ascq;
        b[15] = {ksv, kbits};
        {b[16], b[17]} = s16;
        {b[20], b[21], b[22], b[23]} = vend;
        return b[i];
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (e !== s) begin
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
            num_errors++;
        end
    endtask

    task automatic results();
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            results();
        end
    endtask

    // AXI4-Lite write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(n, 100);
        chk("bresp", er, bresp);
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        rd = rdata;
        tmo(n, 100);
        chk("rresp", er, rresp);
    endtask

    // Load the fields, start a report, wait for done and compare what arrived
    task automatic run();
        int n;
        axw(SSD_OFF_CODE, {1'b0, kbits, ascq, asc, 4'h0, key}, SSD_RESP_OKAY);
        axw(SSD_OFF_INFOL, info[31:0], SSD_RESP_OKAY);
        axw(SSD_OFF_INFOH, info[63:32], SSD_RESP_OKAY);
        axw(SSD_OFF_KSPEC, {16'h0000, s16}, SSD_RESP_OKAY);
        axw(SSD_OFF_ALLOC, {24'h000000, alloc}, SSD_RESP_OKAY);
        axw(SSD_OFF_VENDOR, vend, SSD_RESP_OKAY);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        axw(SSD_OFF_CTRL, {8'h00, opc, 7'h00, mm, ksv, cdb, prior, infov, reqs, defer, dsel, 1'b1}, SSD_RESP_OKAY);
        for (n = 0; n < 300; n++) begin
            axr(SSD_OFF_STATUS, SSD_RESP_OKAY);
            if (rd[1:0] == 2'b10) break;
        end
        tmo(n, 300);
        chk("length", exp_len(), rxn);
        chk("sent", exp_len(), rd[22:16]);
        chk("refused", key == SSD_KEY_RSVD, rd[2]);
        chk("inhibit", key == SSD_KEY_ILLEGAL && cdb, inh);
        if (!dsel) begin
            for (n = 0; n < rxn; n++) begin
                chk("byte", exp_byte(n), rx[n]);
            end
        end else if (rxn > 7'h01) begin
            chk("desc code", (defer && prior) ? SSD_RC_DSC_DEF : SSD_RC_DSC_CUR, rx[0][6:0]);
        end
    endtask

    initial begin
        int k;
        k = $urandom(9004);
        {rst, clr, awvalid, wvalid, bready, arvalid, rready} = 7'b1000000;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        axr(SSD_OFF_CTRL, SSD_RESP_OKAY);
        chk("ctrl reset", SSD_RST_WORD, rd);
        axr(8'h20, SSD_RESP_SLVERR);
        axw(SSD_OFF_STATUS, 32'h0, SSD_RESP_SLVERR);
        for (k = 0; k < 11; k++) begin
            key = keys[k];
            {dsel, defer, prior, infov, ksv, cdb} = 6'($urandom);
            {asc, ascq, kbits} = 23'($urandom);
            {s16, vend} = {16'($urandom), $urandom};
            info = {36'h0, 28'($urandom)};
            {reqs, mm, opc, alloc} = {2'b00, 8'h28, 8'hFF};
            if (k < 7 || k == 8 || k == 9) dsel = 1'b0;
            case (k)
                0: {infov, info} = {1'b1, 64'h0000_0000_0FFF_FFFF};
                1: {infov, info} = {1'b1, 64'h0000_0000_1000_0000};
                2: {mm, opc, info} = {1'b1, SSD_OPC_RD_LONG, 64'h0000_0000_0000_0200};
                3: {mm, opc, info} = {1'b1, SSD_OPC_WR_LONG, 64'h0000_0000_FFFF_FE00};
                4: mm = 1'b1;
                5: {reqs, alloc, cdb} = {1'b1, 8'h00, 1'b1};
                6: {reqs, alloc} = {1'b1, 8'h07};
                7: {dsel, reqs} = 2'b11;
                8: {defer, prior} = 2'b10;
                9: {defer, prior} = 2'b11;
                default: ;
            endcase
            run();
        end
        results();
    end
endmodule // ssd_builder_tb_top

/* File: bench/ssd_initiator_model.sv */
// Initiator side model that takes sense bytes with random stalls
`timescale 1ns/1ps
module ssd_initiator_model (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    // Sense stream
    input  wire logic [7:0] sense_data,
    input  wire logic       sense_valid,
    output logic            sense_ready,
    // Captured report
    output logic [7:0]      rx_mem [0:63],
    output logic [6:0]      rx_cnt
);
    // Store bytes in arrival order; count saturates so a runaway stream cannot wrap
    always_ff @(posedge clk) begin
        if (rst || clr) rx_cnt <= 7'h00;
        else if (sense_valid && sense_ready && rx_cnt < 7'h40) begin
            rx_mem[rx_cnt[5:0]] <= sense_data;
            rx_cnt <= rx_cnt + 7'h01;
        end
    end
    // Ready dropped about one cycle in four to stall the builder
    always_ff @(posedge clk) sense_ready <= !rst && ($urandom_range(3, 0) != 0);
endmodule // ssd_initiator_model

/* File: hdl/ssd_builder.sv */
// Sense report builder with AXI4-Lite registers and byte stream output
`timescale 1ns/1ps
module ssd_builder
    import ssd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Sense byte stream toward the initiator link
    output logic [7:0]       sense_data,
    output logic             sense_valid,
    output logic             sense_last,
    input  wire logic        sense_ready,
    // Medium write inhibit toward the media path
    output logic             medium_inhibit
);
    // Bus state
    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic        aw_held_ff, w_held_ff;
    logic [7:0]  aw_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0]  w_strb_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    // Software registers
    logic [31:0] ctrl_ff, code_ff, infol_ff, infoh_ff, kspec_ff, alloc_ff, vendor_ff;
    logic        start_ff;
    // Builder state
    ssd_state_e  state_ff;
    logic [5:0]  idx_ff;
    logic [6:0]  layout_len_ff, xfer_len_ff, sent_ff;
    logic        done_ff, refused_ff, inhibit_ff;
    logic [7:0]  out_data_ff;
    logic        out_valid_ff, out_last_ff;
    logic [7:0]  fill_byte, mem_rdata;
    logic        wr_go;

    // Byte-lane merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction
    // Smaller of allocation length and layout length
    function automatic logic [6:0] clip_len(input logic [7:0] alloc, input logic [6:0] lay);
        return ({1'b0, lay} < alloc) ? lay : alloc[6:0];
    endfunction
    // Decoded fields
    logic        dsense, deferred_eff, ili_eff, valid_eff, long_op;
    logic [3:0]  key;
    logic [63:0] info;
    logic [6:0]  rc;
    assign dsense       = ctrl_ff[SSD_CTRL_DSENSE];
    assign key          = code_ff[3:0];
    assign info         = {infoh_ff, infol_ff};
    assign long_op      = (ctrl_ff[SSD_CTRL_OPC_LSB +: 8] == SSD_OPC_RD_LONG) ||
                          (ctrl_ff[SSD_CTRL_OPC_LSB +: 8] == SSD_OPC_WR_LONG);
    assign deferred_eff = ctrl_ff[SSD_CTRL_DEFER] && ctrl_ff[SSD_CTRL_PRIORGD];
    assign ili_eff      = ctrl_ff[SSD_CTRL_MISMATCH] && long_op;
    // Residues are 32-bit two's complement, so only fixed-layout addresses face the ceiling
    assign valid_eff    = (ctrl_ff[SSD_CTRL_INFOV] || ili_eff) &&
                          (ili_eff || dsense || info <= SSD_INFO_MAX);
    always_comb begin
        case ({dsense, deferred_eff})
            2'b00:   rc = SSD_RC_FIX_CUR;
            2'b01:   rc = SSD_RC_FIX_DEF;
            2'b10:   rc = SSD_RC_DSC_CUR;
            default: rc = SSD_RC_DSC_DEF;
        endcase
    end
    // Content of the byte at the fill index, most significant byte first
    always_comb begin
        fill_byte = 8'h00;
        if (!dsense) begin
            case (idx_ff)
                6'd0:  fill_byte = {valid_eff, rc};
                6'd2:  fill_byte = {2'b00, ili_eff, 1'b0, key};
                6'd3:  fill_byte = valid_eff ? infol_ff[31:24] : 8'h00;
                6'd4:  fill_byte = valid_eff ? infol_ff[23:16] : 8'h00;
                6'd5:  fill_byte = valid_eff ? infol_ff[15:8] : 8'h00;
                6'd6:  fill_byte = valid_eff ? infol_ff[7:0] : 8'h00;
                6'd7:  fill_byte = SSD_ADDL_FIXED;
                6'd12: fill_byte = code_ff[15:8];
                6'd13: fill_byte = code_ff[23:16];
                6'd15: fill_byte = {ctrl_ff[SSD_CTRL_KSV], code_ff[30:24]};
                6'd16: fill_byte = kspec_ff[15:8];
                6'd17: fill_byte = kspec_ff[7:0];
                6'd20: fill_byte = vendor_ff[31:24];
                6'd21: fill_byte = vendor_ff[23:16];
                6'd22: fill_byte = vendor_ff[15:8];
                6'd23: fill_byte = vendor_ff[7:0];
                default: fill_byte = 8'h00;
            endcase
        end else begin
            // Descriptor header plus one information descriptor
            case (idx_ff)
                6'd0:  fill_byte = {1'b0, rc};
                6'd1:  fill_byte = {4'h0, key};
                6'd2:  fill_byte = code_ff[15:8];
                6'd3:  fill_byte = code_ff[23:16];
                6'd7:  fill_byte = SSD_ADDL_DESC;
                6'd8:  fill_byte = SSD_INFO_DTYPE;
                6'd9:  fill_byte = SSD_INFO_DLEN;
                6'd10: fill_byte = {valid_eff, 7'h00};
                6'd12, 6'd13, 6'd14, 6'd15, 6'd16, 6'd17, 6'd18, 6'd19:
                    fill_byte = valid_eff ? info[(19 - idx_ff) * 8 +: 8] : 8'h00;
                default: fill_byte = 8'h00;
            endcase
        end
    end
    // Write address and data are taken in either order, then applied together
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= SSD_RST_WORD;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= SSD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && awready_ff) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= (aw_addr_ff[1:0] == 2'b00 && aw_addr_ff <= SSD_OFF_VENDOR &&
                               aw_addr_ff != SSD_OFF_STATUS) ? SSD_RESP_OKAY : SSD_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end
    // Software registers; frozen while a report is in flight so it stays consistent
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff   <= SSD_RST_WORD;
            code_ff   <= SSD_RST_WORD;
            infol_ff  <= SSD_RST_WORD;
            infoh_ff  <= SSD_RST_WORD;
            kspec_ff  <= SSD_RST_WORD;
            alloc_ff  <= SSD_RST_WORD;
            vendor_ff <= SSD_RST_WORD;
            start_ff  <= 1'b0;
        end else if (ce) begin
            start_ff <= 1'b0;
            if (wr_go && state_ff == SSD_IDLE && !start_ff) begin
                case (aw_addr_ff)
                    SSD_OFF_CTRL: begin
                        ctrl_ff  <= merge(ctrl_ff, w_data_ff, w_strb_ff) & 32'hFFFF_FFFE;
                        start_ff <= w_strb_ff[0] && w_data_ff[SSD_CTRL_START];
                    end
                    SSD_OFF_CODE:   code_ff   <= merge(code_ff, w_data_ff, w_strb_ff);
                    SSD_OFF_INFOL:  infol_ff  <= merge(infol_ff, w_data_ff, w_strb_ff);
                    SSD_OFF_INFOH:  infoh_ff  <= merge(infoh_ff, w_data_ff, w_strb_ff);
                    SSD_OFF_KSPEC:  kspec_ff  <= merge(kspec_ff, w_data_ff, w_strb_ff);
                    SSD_OFF_ALLOC:  alloc_ff  <= merge(alloc_ff, w_data_ff, w_strb_ff);
                    SSD_OFF_VENDOR: vendor_ff <= merge(vendor_ff, w_data_ff, w_strb_ff);
                    default: ;
                endcase
            end
        end
    end
    // Read channel; one read in flight, answer one cycle after the address
    always_ff @(posedge clk) begin
        if (rst) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= SSD_RST_WORD;
            rresp_ff   <= SSD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rresp_ff   <= SSD_RESP_OKAY;
                case (s_axi_araddr)
                    SSD_OFF_CTRL:   rdata_ff <= ctrl_ff;
                    SSD_OFF_STATUS: rdata_ff <= {9'h000, sent_ff, 1'b0, xfer_len_ff, 4'h0,
                                                 inhibit_ff, refused_ff, done_ff, state_ff != SSD_IDLE};
                    SSD_OFF_CODE:   rdata_ff <= code_ff;
                    SSD_OFF_INFOL:  rdata_ff <= infol_ff;
                    SSD_OFF_INFOH:  rdata_ff <= infoh_ff;
                    SSD_OFF_KSPEC:  rdata_ff <= kspec_ff;
                    SSD_OFF_ALLOC:  rdata_ff <= alloc_ff;
                    SSD_OFF_VENDOR: rdata_ff <= vendor_ff;
                    default: begin
                        rdata_ff <= SSD_RST_WORD;
                        rresp_ff <= SSD_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end
    // Build the whole layout into the buffer, then send the clipped length
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff      <= SSD_IDLE;
            idx_ff        <= 6'd0;
            layout_len_ff <= 7'd0;
            xfer_len_ff   <= 7'd0;
            sent_ff       <= 7'd0;
            done_ff       <= 1'b0;
            refused_ff    <= 1'b0;
            inhibit_ff    <= 1'b0;
            out_data_ff   <= 8'h00;
            out_valid_ff  <= 1'b0;
            out_last_ff   <= 1'b0;
        end else if (ce) begin
            case (state_ff)
                SSD_IDLE: begin
                    if (start_ff) begin
                        sent_ff    <= 7'd0;
                        idx_ff     <= 6'd0;
                        refused_ff <= (key == SSD_KEY_RSVD);
                        inhibit_ff <= (key == SSD_KEY_ILLEGAL) && ctrl_ff[SSD_CTRL_CDBERR];
                        layout_len_ff <= dsense ? SSD_LEN_DESC : SSD_LEN_FIXED;
                        xfer_len_ff <= ctrl_ff[SSD_CTRL_REQSENSE] ?
                                       clip_len(alloc_ff[7:0], dsense ? SSD_LEN_DESC : SSD_LEN_FIXED) :
                                       (dsense ? SSD_LEN_DESC : SSD_LEN_FIXED);
                        state_ff <= (key == SSD_KEY_RSVD) ? SSD_IDLE : SSD_FILL;
                        done_ff  <= (key == SSD_KEY_RSVD);
                    end
                end
                SSD_FILL: begin
                    if ({1'b0, idx_ff} == layout_len_ff - 7'd1) begin
                        idx_ff   <= 6'd0;
                        state_ff <= (xfer_len_ff == 7'd0) ? SSD_IDLE : SSD_RD;
                        done_ff  <= (xfer_len_ff == 7'd0);
                    end else begin
                        idx_ff <= idx_ff + 6'd1;
                    end
                end
                SSD_RD: state_ff <= SSD_LOAD;
                SSD_LOAD: begin
                    out_data_ff  <= mem_rdata;
                    out_valid_ff <= 1'b1;
                    out_last_ff  <= ({1'b0, idx_ff} == xfer_len_ff - 7'd1);
                    state_ff     <= SSD_HOLD;
                end
                SSD_HOLD: begin
                    if (sense_ready) begin
                        out_valid_ff <= 1'b0;
                        out_last_ff  <= 1'b0;
                        sent_ff      <= sent_ff + 7'd1;
                        idx_ff       <= idx_ff + 6'd1;
                        state_ff     <= out_last_ff ? SSD_IDLE : SSD_RD;
                        done_ff      <= out_last_ff;
                    end
                end
                default: state_ff <= SSD_IDLE;
            endcase
        end
    end
    // Report buffer; written during fill, read while sending
    ssd_sense_mem u_mem (
        .clk      (clk),
        .ce       (ce),
        .we       (state_ff == SSD_FILL),
        .waddr    (idx_ff),
        .wdata    (fill_byte),
        .raddr    (idx_ff),
        .rdata_ff (mem_rdata)
    );
    // Outputs straight from flip-flops
    assign s_axi_awready  = awready_ff;
    assign s_axi_wready   = wready_ff;
    assign s_axi_bvalid   = bvalid_ff;
    assign s_axi_bresp    = bresp_ff;
    assign s_axi_arready  = arready_ff;
    assign s_axi_rvalid   = rvalid_ff;
    assign s_axi_rdata    = rdata_ff;
    assign s_axi_rresp    = rresp_ff;
    assign sense_data     = out_data_ff;
    assign sense_valid    = out_valid_ff;
    assign sense_last     = out_last_ff;
    assign medium_inhibit = inhibit_ff;
endmodule // ssd_builder

/* File: hdl/ssd_pkg.sv */
// Constants and types shared by the sense report builder
package ssd_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] SSD_OFF_CTRL   = 8'h00;
    localparam logic [7:0] SSD_OFF_STATUS = 8'h04;
    localparam logic [7:0] SSD_OFF_CODE   = 8'h08;
    localparam logic [7:0] SSD_OFF_INFOL  = 8'h0C;
    localparam logic [7:0] SSD_OFF_INFOH  = 8'h10;
    localparam logic [7:0] SSD_OFF_KSPEC  = 8'h14;
    localparam logic [7:0] SSD_OFF_ALLOC  = 8'h18;
    localparam logic [7:0] SSD_OFF_VENDOR = 8'h1C;

    // Control register bit positions
    localparam int SSD_CTRL_START    = 0;
    localparam int SSD_CTRL_DSENSE   = 1;
    localparam int SSD_CTRL_DEFER    = 2;
    localparam int SSD_CTRL_REQSENSE = 3;
    localparam int SSD_CTRL_INFOV    = 4;
    localparam int SSD_CTRL_PRIORGD  = 5;
    localparam int SSD_CTRL_CDBERR   = 6;
    localparam int SSD_CTRL_KSV      = 7;
    localparam int SSD_CTRL_MISMATCH = 8;
    localparam int SSD_CTRL_OPC_LSB  = 16;

    // Reset values
    localparam logic [31:0] SSD_RST_WORD = 32'h0000_0000;

    // Report layout figures
    localparam logic [6:0] SSD_LEN_FIXED = 7'h20;   // 32 bytes
    localparam logic [6:0] SSD_LEN_DESC  = 7'h3C;   // 60 bytes
    localparam logic [7:0] SSD_ADDL_FIXED = 8'h18;
    localparam logic [7:0] SSD_ADDL_DESC  = 8'h34;  // 60 minus 8-byte header
    localparam logic [6:0] SSD_RC_FIX_CUR = 7'h70;
    localparam logic [6:0] SSD_RC_FIX_DEF = 7'h71;
    localparam logic [6:0] SSD_RC_DSC_CUR = 7'h72;
    localparam logic [6:0] SSD_RC_DSC_DEF = 7'h73;
    localparam logic [63:0] SSD_INFO_MAX  = 64'h0000_0000_0FFF_FFFF;
    localparam logic [7:0] SSD_INFO_DTYPE = 8'h00;
    localparam logic [7:0] SSD_INFO_DLEN  = 8'h0A;

    // Opcodes and keys
    localparam logic [7:0] SSD_OPC_RD_LONG = 8'h3E;
    localparam logic [7:0] SSD_OPC_WR_LONG = 8'h3F;
    localparam logic [3:0] SSD_KEY_ILLEGAL = 4'h5;
    localparam logic [3:0] SSD_KEY_RSVD    = 4'hF;

    // AXI responses
    localparam logic [1:0] SSD_RESP_OKAY   = 2'b00;
    localparam logic [1:0] SSD_RESP_SLVERR = 2'b10;

    // Builder states, Gray coded from SSD_IDLE through SSD_FILL, SSD_RD and SSD_LOAD to SSD_HOLD
    typedef enum logic [2:0] {
        SSD_IDLE = 3'b000,
        SSD_FILL = 3'b001,
        SSD_RD   = 3'b011,
        SSD_LOAD = 3'b010,
        SSD_HOLD = 3'b110
    } ssd_state_e;

endpackage

/* File: hdl/ssd_sense_mem.sv */
// Byte buffer holding one assembled sense report
`timescale 1ns/1ps
module ssd_sense_mem (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       ce,
    // Write port
    input  wire logic       we,
    input  wire logic [5:0] waddr,
    input  wire logic [7:0] wdata,
    // Read port, data registered
    input  wire logic [5:0] raddr,
    output logic      [7:0] rdata_ff
);
    logic [7:0] mem [0:63];

    // Storage needs no reset; every byte sent is written first
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read keeps the output path short
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata_ff <= mem[raddr];
        end
    end
endmodule // ssd_sense_mem
